//--- hdl/unary_op_pkg.sv
package unary_op_pkg;

    localparam int unsigned DATA_W    = 8;
    localparam int unsigned ADDR_W    = 7;
    localparam int unsigned INSTR_W   = 14;

    // instruction word layout
    localparam int unsigned OPC_MSB   = 13;
    localparam int unsigned OPC_LSB   = 8;
    localparam int unsigned DEST_BIT  = 7;
    localparam int unsigned ADDR_MSB  = 6;

    // top six bits of each recognised instruction
    localparam logic [5:0] OPC_DECREMENT = 6'h03;
    localparam logic [5:0] OPC_INVERT    = 6'h09;
    localparam logic [5:0] OPC_DEC_SKIP  = 6'h0b;

    // destination select values
    localparam logic DEST_ACC = 1'h0;
    localparam logic DEST_REG = 1'h1;

    // reset values and the decrement step
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
    localparam logic              FLAG_RST = 1'h0;
    localparam logic [DATA_W-1:0] ONE      = 8'h01;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_DECREMENT,
        OP_INVERT,
        OP_DEC_SKIP
    } unary_op_e;

    typedef enum logic {
        SEQ_EXEC,
        SEQ_SKIP
    } seq_e;

    typedef struct packed {
        seq_e              seq;
        logic              acc_we;
        logic [DATA_W-1:0] acc_data;
        logic              reg_we;
        logic [ADDR_W-1:0] reg_addr;
        logic [DATA_W-1:0] reg_data;
        logic              flag_we;
        logic              null_flag;
        logic              squash;
        logic              done;
    } unary_state_s;

    function automatic unary_op_e decode_op(input logic [INSTR_W-1:0] word);
        unary_op_e op;
        op = OP_NONE;
        case (word[OPC_MSB:OPC_LSB])
            OPC_DECREMENT: op = OP_DECREMENT;
            OPC_INVERT:    op = OP_INVERT;
            OPC_DEC_SKIP:  op = OP_DEC_SKIP;
            default:       op = OP_NONE;
        endcase
        return op;
    endfunction

endpackage

//--- hdl/unary_op_if.sv
`timescale 1ns/100ps
interface unary_op_if;
    import unary_op_pkg::*;

    unary_op_e         kind;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result;
    logic              result_null;

    modport core (output kind, output operand, input result, input result_null);
    modport alu  (input kind, input operand, output result, output result_null);
endinterface

//--- hdl/unary_alu.sv
`timescale 1ns/100ps
module unary_alu
    import unary_op_pkg::*;
(
    unary_op_if.alu op
);

    always_comb begin
        case (op.kind)
            // 8-bit subtract wraps 0x00 to 0xff by width alone
            OP_DECREMENT: op.result = op.operand - ONE;
            OP_DEC_SKIP:  op.result = op.operand - ONE;
            OP_INVERT:    op.result = ~op.operand;
            default:      op.result = op.operand;
        endcase
        op.result_null = (op.result == DATA_RST);
    end

endmodule

//--- hdl/unary_file_op_decode.sv
`timescale 1ns/100ps
module unary_file_op_decode
    import unary_op_pkg::*;
#(
    parameter int unsigned DATA_WIDTH = DATA_W,
    parameter int unsigned ADDR_WIDTH = ADDR_W
)
(
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_resetn,
    // instruction cycle enable and issued word
    input  wire logic               i_cycle_en,
    input  wire logic               i_issue,
    input  wire logic [INSTR_W-1:0] i_instr,
    // contents of the addressed register, read by the core
    input  wire logic [DATA_W-1:0]  i_operand,
    // accumulator write
    output logic                    o_acc_we,
    output logic [DATA_W-1:0]       o_acc_data,
    // register file write back
    output logic                    o_reg_we,
    output logic [ADDR_W-1:0]       o_reg_addr,
    output logic [DATA_W-1:0]       o_reg_data,
    // status
    output logic                    o_flag_we,
    output logic                    o_null_flag,
    output logic                    o_squash,
    output logic                    o_done
);

    ////////////////////////////////////////////////////////////////////////////
    // the datapath and field slicing are built on the package layout; a width
    // or field position that the logic cannot serve is refused here
    generate
        if (DATA_WIDTH != DATA_W) begin : g_bad_data_width
            $error("data width must equal the package data width");
        end

        if (ADDR_WIDTH != ADDR_W) begin : g_bad_addr_width
            $error("address width must equal the package address width");
        end

        if (OPC_MSB != INSTR_W - 1) begin : g_bad_opc_msb
            $error("opcode field must end at the top bit of the word");
        end

        if (OPC_LSB != DEST_BIT + 1) begin : g_bad_opc_lsb
            $error("opcode field must sit directly above the destination bit");
        end

        if (DEST_BIT != ADDR_W) begin : g_bad_dest_bit
            $error("destination bit must sit directly above the address field");
        end

        if (ADDR_MSB != ADDR_W - 1) begin : g_bad_addr_msb
            $error("address field must span the full address width");
        end

        if ($bits(OPC_DECREMENT) != OPC_MSB - OPC_LSB + 1) begin : g_bad_opc_width
            $error("opcode constants must match the opcode field width");
        end

        if (OPC_DECREMENT == OPC_INVERT) begin : g_dup_opc_a
            $error("decrement and invert opcodes must differ");
        end

        if (OPC_DECREMENT == OPC_DEC_SKIP) begin : g_dup_opc_b
            $error("decrement and skip opcodes must differ");
        end

        if (OPC_INVERT == OPC_DEC_SKIP) begin : g_dup_opc_c
            $error("invert and skip opcodes must differ");
        end

        if (DEST_ACC == DEST_REG) begin : g_dup_dest
            $error("the two destination select values must differ");
        end

        if ($bits(DATA_RST) != DATA_WIDTH) begin : g_bad_data_rst
            $error("data reset value must match the data width");
        end

        if ($bits(ADDR_RST) != ADDR_WIDTH) begin : g_bad_addr_rst
            $error("address reset value must match the address width");
        end

        if ($bits(ONE) != DATA_WIDTH) begin : g_bad_one
            $error("decrement step must match the data width");
        end

        if (INSTR_W != OPC_MSB - OPC_LSB + 1 + 1 + ADDR_W) begin : g_bad_instr_w
            $error("word width must equal opcode, destination and address fields");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // value held while reset is low; also the idle state of the sequencer
    function automatic unary_state_s reset_state();
        unary_state_s st;
        st           = '0;
        st.seq       = SEQ_EXEC;
        st.acc_we    = 1'h0;
        st.acc_data  = DATA_RST;
        st.reg_we    = 1'h0;
        st.reg_addr  = ADDR_RST;
        st.reg_data  = DATA_RST;
        st.flag_we   = 1'h0;
        st.null_flag = FLAG_RST;
        st.squash    = 1'h0;
        st.done      = 1'h0;
        return st;
    endfunction

    // data, address and flag keep their values; only the pulses drop
    function automatic unary_state_s clear_strobes(input unary_state_s st);
        unary_state_s nx;
        nx         = st;
        nx.acc_we  = 1'h0;
        nx.reg_we  = 1'h0;
        nx.flag_we = 1'h0;
        nx.squash  = 1'h0;
        nx.done    = 1'h0;
        return nx;
    endfunction

    // decrement and invert own the null flag; the skip form leaves it alone
    function automatic logic updates_flag(input unary_op_e k);
        return (k == OP_DECREMENT) || (k == OP_INVERT);
    endfunction

    // only a skip form that reaches zero throws away the fetched word
    function automatic logic skips_next(input unary_op_e k, input logic is_null);
        return (k == OP_DEC_SKIP) && is_null;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    unary_op_if   op ();
    unary_state_s s_q;
    unary_state_s s_d;
    unary_op_e    kind;
    logic         take;
    logic         dest;

    assign kind = decode_op(i_instr);
    assign dest = i_instr[DEST_BIT];
    // the word issued in a skip cycle is the squashed one and never runs
    assign take = i_cycle_en && i_issue && (s_q.seq == SEQ_EXEC) && (kind != OP_NONE);

    assign op.kind    = kind;
    assign op.operand = i_operand;

    unary_alu u_alu (
        .op (op.alu)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        // strobes are one clock wide so the core sees each write once
        s_d = clear_strobes(s_q);
        if (i_cycle_en) begin
            case (s_q.seq)
                SEQ_EXEC: begin
                    if (take) begin
                        s_d.done     = 1'h1;
                        s_d.reg_addr = i_instr[ADDR_MSB:0];
                        if (dest == DEST_ACC) begin
                            s_d.acc_we   = 1'h1;
                            s_d.acc_data = op.result;
                        end else begin
                            s_d.reg_we   = 1'h1;
                            s_d.reg_data = op.result;
                        end
                        if (updates_flag(kind)) begin
                            // set on zero, cleared on any non-zero result
                            s_d.flag_we   = 1'h1;
                            s_d.null_flag = op.result_null;
                        end
                        // flags untouched by the skip form
                        if (skips_next(kind, op.result_null)) begin
                            s_d.squash = 1'h1;
                            s_d.seq    = SEQ_SKIP;
                        end
                    end
                end
                SEQ_SKIP: begin
                    // second cycle of the skip form acts as a no-operation
                    s_d.seq = SEQ_EXEC;
                end
                default: begin
                    s_d.seq = SEQ_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            s_q <= reset_state();
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign o_acc_we    = s_q.acc_we;
    assign o_acc_data  = s_q.acc_data;
    assign o_reg_we    = s_q.reg_we;
    assign o_reg_addr  = s_q.reg_addr;
    assign o_reg_data  = s_q.reg_data;
    assign o_flag_we   = s_q.flag_we;
    assign o_null_flag = s_q.null_flag;
    assign o_squash    = s_q.squash;
    assign o_done      = s_q.done;

endmodule

//--- bench/unary_file_op_decode_checker.sv
`timescale 1ns/100ps
module unary_file_op_decode_checker
    import unary_op_pkg::*;
(
    input wire logic               i_clk, i_resetn, i_cycle_en, i_issue,
    input wire logic [INSTR_W-1:0] i_instr,
    input wire logic [DATA_W-1:0]  i_operand, o_acc_data, o_reg_data,
    input wire logic [ADDR_W-1:0]  o_reg_addr,
    input wire logic               o_acc_we, o_reg_we, o_flag_we, o_null_flag, o_squash, o_done
);
    // skip lasts until the next enable, which may come clocks after the squash pulse
    logic       skp_q;
    wire  [5:0] opc = i_instr[13:8];
    wire        skp = o_squash | skp_q;
    wire        go  = i_cycle_en & i_issue & ~skp;
    wire  [7:0] res = o_acc_we ? o_acc_data : o_reg_data;
    wire        dsk = go && opc == OPC_DEC_SKIP;
    wire        any = go && (opc == OPC_DECREMENT || opc == OPC_INVERT || dsk);
    always_ff @(posedge i_clk) skp_q <= i_resetn & skp & ~i_cycle_en;
    ////////////////////////////////////////////////////////////
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    a_dec_value: assert property (go && opc == OPC_DECREMENT |=>
        o_flag_we && res == $past(i_operand) - ONE) else $error("dec value");
    a_inv_value: assert property (go && opc == OPC_INVERT |=>
        o_flag_we && res == ~$past(i_operand)) else $error("inv value");
    a_dest_select: assert property (any |=> o_done && o_acc_we != o_reg_we &&
        o_reg_we == $past(i_instr[7]) && o_reg_addr == $past(i_instr[6:0])) else $error("dest");
    a_null_flag: assert property (o_flag_we |-> o_null_flag == (res == DATA_RST))
        else $error("null flag");
    a_skip_flags: assert property (dsk |=> !o_flag_we && $stable(o_null_flag))
        else $error("skip flags");
    a_skip_squash: assert property (dsk |=> o_squash == ($past(i_operand) == ONE))
        else $error("squash");
    a_ignore_other: assert property (!any |=> !o_done && !o_acc_we && !o_reg_we && !o_squash)
        else $error("ignored");
    a_flag_hold: assert property (!o_flag_we |-> $stable(o_null_flag))
        else $error("flag hold");
endmodule
bind unary_file_op_decode unary_file_op_decode_checker chk (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_cycle_en  (i_cycle_en),
    .i_issue     (i_issue),
    .i_instr     (i_instr),
    .i_operand   (i_operand),
    .o_acc_data  (o_acc_data),
    .o_reg_data  (o_reg_data),
    .o_reg_addr  (o_reg_addr),
    .o_acc_we    (o_acc_we),
    .o_reg_we    (o_reg_we),
    .o_flag_we   (o_flag_we),
    .o_null_flag (o_null_flag),
    .o_squash    (o_squash),
    .o_done      (o_done)
);

//--- bench/test_unary_file_op_decode.sv
`timescale 1ns/100ps
module test_unary_file_op_decode
    import unary_op_pkg::*;
;
    logic               i_clk = 0, i_resetn = 0, i_cycle_en = 0, i_issue = 0;
    logic [INSTR_W-1:0] i_instr = '0;
    logic [DATA_W-1:0]  i_operand = '0, o_acc_data, o_reg_data;
    logic [ADDR_W-1:0]  o_reg_addr;
    logic               o_acc_we, o_reg_we, o_flag_we, o_null_flag, o_squash, o_done;
    logic               sk = 0, fl = 0;
    logic [5:0]         ops [5] = '{OPC_DECREMENT, OPC_INVERT, OPC_DEC_SKIP, 6'h0f, 6'h00};
    int                 errors = 0, n_compared = 0;
    unary_file_op_decode dut (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_cycle_en  (i_cycle_en),
        .i_issue     (i_issue),
        .i_instr     (i_instr),
        .i_operand   (i_operand),
        .o_acc_we    (o_acc_we),
        .o_acc_data  (o_acc_data),
        .o_reg_we    (o_reg_we),
        .o_reg_addr  (o_reg_addr),
        .o_reg_data  (o_reg_data),
        .o_flag_we   (o_flag_we),
        .o_null_flag (o_null_flag),
        .o_squash    (o_squash),
        .o_done      (o_done)
    );
    always #12.5 i_clk = ~i_clk;
    task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic run(logic [13:0] w, logic [7:0] v, logic en);
        logic [5:0] op;
        logic [7:0] r;
        logic       ex;
        op = w[13:8];
        r  = op == OPC_INVERT ? ~v : v - ONE;
        ex = en && !sk && (op == OPC_DECREMENT || op == OPC_INVERT || op == OPC_DEC_SKIP);
        {i_cycle_en, i_issue, i_instr, i_operand} = {en, 1'b1, w, v};
        @(posedge i_clk);
        #1;
        chk("done", o_done, ex);
        if (ex) begin
            if (op != OPC_DEC_SKIP) fl = r == 0;
            sk = op == OPC_DEC_SKIP && r == 0;
            chk("data", w[7] ? o_reg_data : o_acc_data, r);
            chk("reg we", o_reg_we, w[7]);
            chk("acc we", o_acc_we, !w[7]);
            chk("addr", o_reg_addr, w[6:0]);
            chk("flag we", o_flag_we, op != OPC_DEC_SKIP);
            chk("squash", o_squash, sk);
        end else if (en) sk = 0;
        chk("flag", o_null_flag, fl);
    endtask
    initial begin
        void'($urandom(32'h298f9cf3));
        repeat (20) @(posedge i_clk);
        #1 i_resetn = 1;
        run(14'h0390, 8'h01, 1);
        run(14'h0913, 8'h13, 1);
        run(14'h0b80, 8'h01, 1);
        run(14'h0390, 8'h05, 1);
        run(14'h0b05, 8'h02, 1);
        run(14'h0385, 8'h00, 1);
        run(14'h0f00, 8'h01, 1);
        repeat (400) run({ops[$urandom % 5], 8'($urandom)},
            $urandom % 3 ? 8'($urandom) : 8'h01, $urandom % 4 != 0);
        // mid-run reset: all outputs and the skip state return to reset values
        {i_cycle_en, i_issue} = 2'b00;
        i_resetn = 0;
        repeat (2) @(posedge i_clk);
        #1 i_resetn = 1;
        sk = 0;
        fl = 0;
        chk("rst acc we", o_acc_we, 8'h00);
        chk("rst acc data", o_acc_data, 8'h00);
        chk("rst reg we", o_reg_we, 8'h00);
        chk("rst reg addr", o_reg_addr, 8'h00);
        chk("rst reg data", o_reg_data, 8'h00);
        chk("rst flag we", o_flag_we, 8'h00);
        chk("rst flag", o_null_flag, 8'h00);
        chk("rst squash", o_squash, 8'h00);
        chk("rst done", o_done, 8'h00);
        run(14'h0b80, 8'h01, 1);
        run(14'h0390, 8'h02, 1);
        run(14'h0390, 8'h02, 1);
        wrap_up;
    end
    initial begin
        #(25 * 4000);
        errors++;
        wrap_up;
    end
endmodule
